// ---- hw/mpsc_defs.vh ----
// Constants for the multiphase spread clock generator core
`ifndef MPSC_DEFS_VH
`define MPSC_DEFS_VH

`define MPSC_NUM_OUT        8
`define MPSC_CODE_HIZ       3'h0
`define MPSC_CODE_LOW       3'h1
`define MPSC_CODE_TAP3      3'h2
`define MPSC_TAP_OFFSET     4'h1
`define MPSC_STARTUP_CYC    8'h80
`define MPSC_LFSR_W         15
`define MPSC_LFSR_SEED      15'h0001
`define MPSC_LFSR_TAP_HI    14
`define MPSC_LFSR_TAP_LO    13
`define MPSC_STEP_W         7
`define MPSC_STEP_LSB       0
`define MPSC_STEP_MID       7'h40
`define MPSC_RATE_16        7'h10
`define MPSC_RATE_32        7'h20
`define MPSC_RATE_64        7'h40
// Sense pair {high, low}; neither asserted means the pin floats
`define MPSC_RATE_SEL_FLOAT 2'h0
`define MPSC_RATE_SEL_LOW   2'h1
`define MPSC_RATE_SEL_HIGH  2'h2
`define MPSC_DET_WIN        8'h40
`define MPSC_DET_EDGES      4'h8

`endif

// ---- hw/mpsc_lfsr.v ----
// Fifteen-bit maximal-length shift register for frequency spreading
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_defs.vh"

module mpsc_lfsr (
  // Clock and reset
  input  wire                            ref_clk,
  input  wire                            resetn,
  // Control
  input  wire                            advance,
  // State
  output reg  [`MPSC_LFSR_W-1:0]         lfsr_q
);

  wire [`MPSC_LFSR_W-1:0] lfsr_d;
  wire                    fb;

  // x^15 + x^14 + 1, maximal length
  assign fb     = lfsr_q[`MPSC_LFSR_TAP_HI] ^ lfsr_q[`MPSC_LFSR_TAP_LO];
  assign lfsr_d = {lfsr_q[`MPSC_LFSR_W-2:0], fb};

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_q <= `MPSC_LFSR_SEED;
    end else if (advance) begin
      // All-zero lockup is escaped by reseeding
      lfsr_q <= (lfsr_d == {`MPSC_LFSR_W{1'b0}}) ? `MPSC_LFSR_SEED : lfsr_d;
    end
  end

endmodule // mpsc_lfsr

`default_nettype wire

// ---- hw/mpsc_core.v ----
// Digital core of the multiphase spread clock generator
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_defs.vh"

module mpsc_core (
  // Clock and reset
  input  wire                             ref_clk,
  input  wire                             resetn,
  // Spacing code pins
  input  wire                             spacing_code_b0,
  input  wire                             spacing_code_b1,
  input  wire                             spacing_code_b2,
  // Rate select pin, three-level: high, low, float sensed
  input  wire                             rate_pin_high,
  input  wire                             rate_pin_low,
  // Clock outputs
  output reg  [`MPSC_NUM_OUT-1:0]         clk_out_q,
  output reg  [`MPSC_NUM_OUT-1:0]         clk_out_oe_q,
  // Spreading status and step converter code
  output reg                              spread_spectrum_mode_q,
  output reg  [`MPSC_STEP_W-1:0]          step_converter_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [2:0] code_m_q;
  reg  [2:0] code_q;
  reg  [1:0] rate_m_q;
  reg  [1:0] rate_s_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      code_m_q <= `MPSC_CODE_HIZ;
      code_q   <= `MPSC_CODE_HIZ;
      rate_m_q <= `MPSC_RATE_SEL_LOW;
      rate_s_q <= `MPSC_RATE_SEL_LOW;
    end else begin
      code_m_q <= {spacing_code_b2, spacing_code_b1, spacing_code_b0};
      code_q   <= code_m_q;
      rate_m_q <= {rate_pin_high, rate_pin_low};
      rate_s_q <= rate_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up muting
  reg  [7:0] start_cnt_q;
  wire       started;

  assign started = (start_cnt_q == `MPSC_STARTUP_CYC);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_cnt_q <= 8'h00;
    end else if (!started) begin
      start_cnt_q <= start_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap count and shared phase counter
  wire       active;
  wire [3:0] tap_count;
  reg  [3:0] phase_q;
  wire       wrap;
  wire       out_period;

  assign active    = (code_q >= `MPSC_CODE_TAP3);
  // Code 010 -> 3 ... 111 -> 8
  assign tap_count = {1'b0, code_q} + `MPSC_TAP_OFFSET;
  assign wrap      = (phase_q >= tap_count - 4'h1);
  assign out_period = wrap & active & started;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 4'h0;
    end else if (!active || !started) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= wrap ? 4'h0 : phase_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  // Output k is high while (phase - k) mod taps < ceil(taps/2); a lag of
  // one master cycle per output spaces them 360/taps apart
  wire [3:0] half_taps;
  assign half_taps = (tap_count + 4'h1) >> 1;

  genvar k;
  generate
    for (k = 0; k < `MPSC_NUM_OUT; k = k + 1) begin : g_out
      wire [3:0] kk;
      wire [3:0] rel;
      wire       used;
      assign kk   = k[3:0];
      assign rel  = (phase_q >= kk) ? (phase_q - kk) : (phase_q + tap_count - kk);
      assign used = kk < tap_count;

      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          clk_out_q[k]    <= 1'b0;
          clk_out_oe_q[k] <= 1'b0;
        end else if (!started || code_q == `MPSC_CODE_HIZ) begin
          clk_out_q[k]    <= 1'b0;
          clk_out_oe_q[k] <= 1'b0;
        end else if (code_q == `MPSC_CODE_LOW) begin
          clk_out_q[k]    <= 1'b0;
          clk_out_oe_q[k] <= 1'b1;
        end else begin
          // Even taps: outputs taps/2 apart are exact inverses
          clk_out_q[k]    <= used & (rel < half_taps);
          clk_out_oe_q[k] <= used;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Rate divider and toggle detector on the rate pin
  reg  [6:0] rate_n;
  reg  [6:0] div_cnt_q;
  reg  [7:0] win_cnt_q;
  reg  [3:0] edge_cnt_q;
  reg        rate_prev_q;
  wire       rate_edge;
  wire       win_end;
  wire       advance;

  always @* begin
    case (rate_s_q)
      `MPSC_RATE_SEL_LOW:   rate_n = `MPSC_RATE_16;
      `MPSC_RATE_SEL_FLOAT: rate_n = `MPSC_RATE_32;
      `MPSC_RATE_SEL_HIGH:  rate_n = `MPSC_RATE_64;
      default:              rate_n = `MPSC_RATE_32;
    endcase
  end

  // Edges on the high sense seen within a window of output periods mean a
  // clock is tied to the pin; a static strap never trips it
  assign rate_edge = rate_s_q[1] ^ rate_prev_q;
  assign win_end   = out_period & (win_cnt_q == `MPSC_DET_WIN - 8'h01);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rate_prev_q            <= 1'b0;
      win_cnt_q              <= 8'h00;
      edge_cnt_q             <= 4'h0;
      spread_spectrum_mode_q <= 1'b0;
    end else begin
      rate_prev_q <= rate_s_q[1];
      if (win_end) begin
        // An edge in the closing cycle opens the next window's count
        win_cnt_q              <= 8'h00;
        edge_cnt_q             <= {3'h0, rate_edge};
        spread_spectrum_mode_q <= (edge_cnt_q < `MPSC_DET_EDGES);
      end else begin
        if (out_period) begin
          win_cnt_q <= win_cnt_q + 8'h01;
        end
        if (rate_edge && edge_cnt_q != 4'hf) begin
          edge_cnt_q <= edge_cnt_q + 4'h1;
        end
      end
    end
  end

  // Shift register steps once per N output periods
  assign advance = out_period & (div_cnt_q == rate_n - 7'h01);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= 7'h00;
    end else if (out_period) begin
      div_cnt_q <= (div_cnt_q >= rate_n - 7'h01) ? 7'h00 : div_cnt_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pseudorandom source and step converter code
  wire [`MPSC_LFSR_W-1:0] lfsr;

  mpsc_lfsr u_lfsr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .advance (advance),
    .lfsr_q  (lfsr)
  );

  // 128 steps; analog side maps code 0..127 onto 0.9..1.1 of nominal;
  // mid-scale holds the fixed frequency when spreading is off
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      step_converter_q <= `MPSC_STEP_MID;
    end else if (!spread_spectrum_mode_q) begin
      step_converter_q <= `MPSC_STEP_MID;
    end else begin
      step_converter_q <= lfsr[`MPSC_STEP_LSB +: `MPSC_STEP_W];
    end
  end

endmodule // mpsc_core

`default_nettype wire

// ---- verif/mpsc_core_asserts.sv ----
// Checker for the multiphase spread clock core
`timescale 1ns/1ps
`default_nettype none
module mpsc_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Pins and outputs
  input wire logic       spacing_code_b0,
  input wire logic       spacing_code_b1,
  input wire logic       spacing_code_b2,
  input wire logic [7:0] clk_out_q,
  input wire logic [7:0] clk_out_oe_q,
  input wire logic       spread_spectrum_mode_q,
  input wire logic [6:0] step_converter_q
);
  wire  [2:0] code = {spacing_code_b2, spacing_code_b1, spacing_code_b0};
  logic [7:0] up_q;
  // Saturates so it cannot wrap back into the startup span
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) up_q <= 8'h00;
    else if (up_q != 8'hff) up_q <= up_q + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////
  property p_hiz; (code == 3'h0)[*5] |-> clk_out_oe_q == 8'h00; endproperty
  a_hiz: assert property (p_hiz) else $error("driven in float code");
  property p_low; (code == 3'h1)[*5] |-> clk_out_q == 8'h00; endproperty
  a_low: assert property (p_low) else $error("high in low code");
  property p_boot; up_q < 8'h80 |-> clk_out_oe_q == 8'h00; endproperty
  a_boot: assert property (p_boot) else $error("driven during startup");
  property p_unused; (code == 3'h3)[*5] |-> clk_out_oe_q[7:4] == 4'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused output driven");
  property p_lag; ((code[2:1] != 2'h0 && $stable(code))[*8] ##0
    (clk_out_oe_q[1] && $past(clk_out_oe_q[1], 2))) |-> clk_out_q[1] == $past(clk_out_q[0]);
  endproperty
  a_lag: assert property (p_lag) else $error("phase lag wrong");
  property p_pair; ((code == 3'h3)[*5] ##0 clk_out_oe_q == 8'h0f)
    |-> clk_out_q[1:0] == ~clk_out_q[3:2]; endproperty
  a_pair: assert property (p_pair) else $error("pair not complementary");
  property p_per; ((code == 3'h3)[*8] ##0 $past(clk_out_oe_q[0], 5)) |->
    clk_out_q[0] == $past(clk_out_q[0], 4) && clk_out_q[0] != $past(clk_out_q[0], 2);
  endproperty
  a_per: assert property (p_per) else $error("period wrong");
  property p_step; spread_spectrum_mode_q && $past(spread_spectrum_mode_q)
    && $changed(step_converter_q) |=> $stable(step_converter_q)[*8]; endproperty
  a_step: assert property (p_step) else $error("step too soon");
endmodule // mpsc_chk
bind mpsc_core mpsc_chk u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .spacing_code_b0(spacing_code_b0), .spacing_code_b1(spacing_code_b1),
  .spacing_code_b2(spacing_code_b2), .clk_out_q(clk_out_q), .clk_out_oe_q(clk_out_oe_q),
  .spread_spectrum_mode_q(spread_spectrum_mode_q), .step_converter_q(step_converter_q));
`default_nettype wire

// ---- verif/mpsc_partner.sv ----
// Far side: rate pin strap and loop-back of the first clock pad
`timescale 1ns/1ps
`default_nettype none
module mpsc_partner (
  // Strap: 0 low, 1 float, 2 high, 3 loop back
  input  wire logic [1:0] rate_mode,
  // Clock pads
  input  wire logic [7:0] clk_out_q,
  input  wire logic [7:0] clk_out_oe_q,
  // Sensed rate pin
  output wire logic       rate_pin_high,
  output wire logic       rate_pin_low
);
  // Undriven pad reads inverted, never a stale level
  wire pad0 = clk_out_oe_q[0] ? clk_out_q[0] : ~clk_out_q[0];
  assign rate_pin_high = (rate_mode == 2'h2) | ((rate_mode == 2'h3) & pad0);
  assign rate_pin_low  = (rate_mode == 2'h0) | ((rate_mode == 2'h3) & ~pad0);
endmodule // mpsc_partner
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the multiphase spread clock core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] code = 3'h3;
  logic [1:0] rate_mode = 2'h0;
  wire        rph;
  wire        rpl;
  wire  [7:0] clk_out_q;
  wire  [7:0] clk_out_oe_q;
  wire        spread_q;
  wire  [6:0] step_q;
  int         n_errors = 0;
  int         compares = 0;
  always #25 ref_clk = ~ref_clk;
  mpsc_core uut (.ref_clk(ref_clk), .resetn(resetn), .spacing_code_b0(code[0]),
    .spacing_code_b1(code[1]), .spacing_code_b2(code[2]), .rate_pin_high(rph),
    .rate_pin_low(rpl), .clk_out_q(clk_out_q), .clk_out_oe_q(clk_out_oe_q),
    .spread_spectrum_mode_q(spread_q), .step_converter_q(step_q));
  mpsc_partner u_far (.rate_mode(rate_mode), .clk_out_q(clk_out_q),
    .clk_out_oe_q(clk_out_oe_q), .rate_pin_high(rph), .rate_pin_low(rpl));
  ////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_code(input logic [2:0] c);
    @(posedge ref_clk) code <= c;
  endtask
  task automatic t_taps;
    int t;
    logic p;
    for (int c = 2; c < 8; c++) begin
      t = c + 1;
      set_code(3'(c));
      cyc(12);
      `CHK(clk_out_oe_q, 8'((1 << t) - 1))
      do begin
        p = clk_out_q[0];
        cyc(1);
      end while (p !== 1'b0 || clk_out_q[0] !== 1'b1);
      `CHK(clk_out_q[1], 1'b0)
      cyc(1);
      `CHK(clk_out_q[1], 1'b1)
      cyc(t - 2);
      `CHK(clk_out_q[0], 1'b0)
      cyc(1);
      `CHK(clk_out_q[0], 1'b1)
      if (t % 2 == 0) `CHK(clk_out_q[0], ~clk_out_q[t / 2])
    end
    $display("taps done");
  endtask
  task automatic t_spread(input logic [1:0] m, input int n);
    logic [6:0] s;
    int hits;
    hits = 0;
    @(posedge ref_clk) rate_mode <= m;
    cyc(400);
    `CHK(spread_q, 1'b1)
    s = step_q;
    while (step_q === s)
      cyc(1);
    for (int k = 1; k <= 12 * n; k++) begin
      s = step_q;
      cyc(1);
      if (step_q !== s) begin
        hits++;
        `CHK(k % (3 * n), 0)
      end
    end
    `CHK(hits > 0, 1'b1)
    $display("spread %0d done", n);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////
  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(100);
    `CHK(clk_out_oe_q, 8'h00)
    cyc(40);
    `CHK(clk_out_oe_q, 8'h0f)
    $display("startup done");
    t_taps();
    // Straight from running clocks, so a missed low mode shows
    set_code(3'h1);
    cyc(6);
    `CHK(clk_out_oe_q, 8'hff)
    `CHK(clk_out_q, 8'h00)
    cyc(9);
    `CHK(clk_out_q, 8'h00)
    set_code(3'h0);
    cyc(6);
    `CHK(clk_out_oe_q, 8'h00)
    $display("static done");
    set_code(3'h2);
    t_spread(2'h0, 16);
    t_spread(2'h1, 32);
    t_spread(2'h2, 64);
    @(posedge ref_clk) rate_mode <= 2'h3;
    cyc(600);
    `CHK(spread_q, 1'b0)
    `CHK(step_q, 7'h40)
    $display("loop back done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
